//--- core/alu_if.sv
// Operand and result bundle between the datapath and its ALU.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ns
interface alu_if;
  import dp_pkg::*;
  alu_op_t          op;
  logic [NIB_W-1:0] a;
  logic [NIB_W-1:0] b;
  logic             cin;
  logic [NIB_W-1:0] y;
  logic             cout;
  logic             zero;
  modport master (output op, a, b, cin, input y, cout, zero);
  modport slave  (input op, a, b, cin, output y, cout, zero);
endinterface

//--- core/core_datapath.sv
// Core datapath: index pointer, return stack, data RAM and ALU.
// Assumes the decoder issues one operation per cycle with valid operands.
`timescale 1ns/1ns
module core_datapath
  import dp_pkg::*;
#(
  parameter int unsigned STACK_LEVELS = STK_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire dp_op_t            op,
  input  wire alu_op_t           alu_op,
  input  wire logic              use_index,
  input  wire logic [DIR_AW-1:0] dir_addr,
  input  wire logic [3:0]        wr_sel,
  input  wire logic [7:0]        imm,
  input  wire logic              imm_operand,
  input  wire logic              alu_to_ram,
  input  wire logic [NIB_W-1:0]  store_data,
  input  wire logic [STK_W-1:0]  pc_in,
  output logic [STK_W-1:0]       ret_pc,
  output logic                   ret_valid,
  output logic                   skip_next,
  output logic [NIB_W-1:0]       accumulator,
  output logic                   carry_flag,
  output logic                   zero_flag,
  output logic [NIB_W-1:0]       wr_data,
  output logic [PTR_W-1:0]       table_addr
);

  ////////////////////////////////////////////////////////////////////////
  // State

  logic [NIB_W-1:0]  ram [RAM_DEPTH];
  logic [STK_W-1:0]  stack [STACK_LEVELS];
  logic [PTR_W-1:0]  index_pointer_r, index_pointer_nxt;
  logic [STK_PW-1:0] sp_r, sp_nxt;
  logic [NIB_W-1:0]  acc_r, acc_nxt;
  logic              cf_r, cf_nxt, zf_r, zf_nxt;
  logic              skip_r, skip_nxt;
  logic [STK_W-1:0]  ret_r, ret_nxt;
  logic              retv_r, retv_nxt;
  logic [NIB_W-1:0]  wrd_r, wrd_nxt;

  logic [RAM_AW-1:0] rd_addr, wr_addr;
  logic [NIB_W-1:0]  ram_rd, wr_rd, ram_wdata;
  logic              ram_we;
  logic              push, pop;
  logic [STK_PW-1:0] pop_idx;

  alu_if alu ();

  nibble_alu u_alu (
    .io (alu.slave)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address selection

  function automatic logic [RAM_AW-1:0] wr_addr_of(input logic [3:0] s);
    return {2'b00, WR_BASE_HI, s};
  endfunction

  function automatic logic [RAM_AW-1:0] dir_addr_of(
    input logic [DIR_AW-1:0] a);
    return {2'b00, a};
  endfunction

  always_comb begin
    if (use_index)
      rd_addr = index_pointer_r[RAM_AW-1:0];
    else
      rd_addr = dir_addr_of(dir_addr);
    ram_rd = ram[rd_addr];
    wr_rd  = ram[wr_addr_of(wr_sel)];
  end

  ////////////////////////////////////////////////////////////////////////
  // ALU hookup

  always_comb begin
    alu.op  = alu_op;
    alu.cin = cf_r;
    alu.a   = acc_r;
    alu.b   = ram_rd;
    if (imm_operand) begin
      alu.a = wr_rd;
      alu.b = imm[NIB_W-1:0];
    end
    if (alu_op == ALU_DAA || alu_op == ALU_DAS)
      alu.a = acc_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    index_pointer_nxt = index_pointer_r;
    acc_nxt   = acc_r;
    cf_nxt    = cf_r;
    zf_nxt    = zf_r;
    skip_nxt  = 1'b0;
    ret_nxt   = ret_r;
    retv_nxt  = 1'b0;
    wrd_nxt   = wrd_r;
    ram_we    = 1'b0;
    wr_addr   = rd_addr;
    ram_wdata = ram_rd;
    push      = 1'b0;
    pop       = 1'b0;
    pop_idx   = sp_r - 3'h1;
    sp_nxt    = sp_r;
    unique case (op)
      OP_ALU: begin
        acc_nxt = alu.y;
        cf_nxt  = alu.cout;
        zf_nxt  = alu.zero;
        if (alu_to_ram) begin
          ram_we    = 1'b1;
          wr_addr   = imm_operand ? wr_addr_of(wr_sel) : rd_addr;
          ram_wdata = alu.y;
        end
      end
      OP_LOAD_LOW:   index_pointer_nxt[3:0]  = ram_rd;
      OP_LOAD_HIGH:  index_pointer_nxt[7:4]  = ram_rd;
      OP_LOAD_UPPER: index_pointer_nxt[11:8] = ram_rd;
      OP_CMP_SKIP:   skip_nxt = (imm == index_pointer_r[7:0]);
      OP_MOVE_TO_WR: begin
        ram_we    = 1'b1;
        wr_addr   = wr_addr_of(wr_sel);
        ram_wdata = ram_rd;
      end
      OP_MOVE_FROM_WR: begin
        ram_we    = 1'b1;
        wr_addr   = dir_addr_of(dir_addr);
        ram_wdata = wr_rd;
      end
      OP_STORE: begin
        ram_we    = 1'b1;
        ram_wdata = store_data;
      end
      OP_CALL: begin
        push   = 1'b1;
        // Full stack wraps naturally through the 3-bit pointer
        sp_nxt = sp_r + 3'h1;
      end
      OP_RET: begin
        pop      = 1'b1;
        // Empty stack wraps to level 7 the same way
        sp_nxt   = pop_idx;
        ret_nxt  = stack[pop_idx];
        retv_nxt = 1'b1;
      end
      default: ;
    endcase
    if (op == OP_LOAD_LOW || op == OP_LOAD_HIGH || op == OP_LOAD_UPPER ||
        op == OP_CMP_SKIP)
      ram_we = 1'b0;
    if (op == OP_MOVE_TO_WR || op == OP_MOVE_FROM_WR || ram_we)
      wrd_nxt = (ram_we && wr_addr == wr_addr_of(wr_sel)) ? ram_wdata
                                                          : wr_rd;
    else
      wrd_nxt = wr_rd;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk) begin
    if (rst) begin
      index_pointer_r <= PTR_RESET;
      sp_r   <= SP_RESET;
      acc_r  <= '0;
      cf_r   <= 1'b0;
      zf_r   <= 1'b0;
      skip_r <= 1'b0;
      ret_r  <= '0;
      retv_r <= 1'b0;
      wrd_r  <= '0;
    end else begin
      index_pointer_r <= index_pointer_nxt;
      sp_r   <= sp_nxt;
      acc_r  <= acc_nxt;
      cf_r   <= cf_nxt;
      zf_r   <= zf_nxt;
      skip_r <= skip_nxt;
      ret_r  <= ret_nxt;
      retv_r <= retv_nxt;
      wrd_r  <= wrd_nxt;
    end
  end

  // Memories are not reset; contents are undefined after power-up
  always_ff @(posedge clk) begin
    if (ram_we)
      ram[wr_addr] <= ram_wdata;
    if (push)
      stack[sp_r] <= pc_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign ret_pc      = ret_r;
  assign ret_valid   = retv_r;
  assign skip_next   = skip_r;
  assign accumulator = acc_r;
  assign carry_flag  = cf_r;
  assign zero_flag   = zf_r;
  assign wr_data     = wrd_r;
  // Pointer feeds table lookup only as an address, never as data
  assign table_addr  = index_pointer_r;

endmodule

//--- core/dp_pkg.sv
// Constants and types for the 4-bit core datapath.
// Assumes one clock and a synchronous active-high reset.
package dp_pkg;

  localparam int unsigned PTR_W      = 12;
  localparam int unsigned NIB_W      = 4;
  localparam int unsigned RAM_AW     = 9;
  localparam int unsigned RAM_DEPTH  = 512;
  localparam int unsigned STK_W      = 11;
  localparam int unsigned STK_DEPTH  = 8;
  localparam int unsigned STK_PW     = 3;
  localparam int unsigned DIR_AW     = 7;
  localparam logic [2:0]  WR_BASE_HI = 3'h7;
  localparam logic [STK_PW-1:0] SP_RESET  = 3'h0;
  localparam logic [PTR_W-1:0]  PTR_RESET = 12'h000;
  localparam logic [NIB_W-1:0]  NIB_NINE  = 4'h9;
  localparam logic [NIB_W-1:0]  NIB_THREE = 4'h3;
  localparam logic [NIB_W-1:0]  NIB_SIX   = 4'h6;
  localparam logic [NIB_W-1:0]  NIB_TEN   = 4'hA;

  typedef enum logic [4:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_INC, ALU_DEC, ALU_AND,
    ALU_EOR, ALU_OR, ALU_SR0, ALU_SR1, ALU_SL0, ALU_SL1, ALU_DAA,
    ALU_DAS, ALU_PASS
  } alu_op_t;

  typedef enum logic [3:0] {
    OP_NONE, OP_ALU, OP_LOAD_LOW, OP_LOAD_HIGH, OP_LOAD_UPPER,
    OP_CMP_SKIP, OP_MOVE_TO_WR, OP_MOVE_FROM_WR, OP_CALL, OP_RET,
    OP_STORE
  } dp_op_t;

endpackage

//--- core/nibble_alu.sv
// Combinational 4-bit ALU with decimal adjust.
// Assumes the caller registers the result and carry.
`timescale 1ns/1ns
module nibble_alu
  import dp_pkg::*;
(
  alu_if.slave io
);

  logic [NIB_W:0] sum;

  always_comb begin
    sum     = '0;
    io.y    = io.a;
    io.cout = io.cin;
    unique case (io.op)
      ALU_ADD: sum = {1'b0, io.a} + {1'b0, io.b};
      ALU_ADC: sum = {1'b0, io.a} + {1'b0, io.b} + {4'h0, io.cin};
      // Carry out is the inverted borrow
      ALU_SUB: sum = {1'b0, io.a} + {1'b0, ~io.b} + 5'h01;
      ALU_SBC: sum = {1'b0, io.a} + {1'b0, ~io.b} + {4'h0, io.cin};
      ALU_INC: sum = {1'b0, io.a} + 5'h01;
      ALU_DEC: sum = {1'b0, io.a} + 5'h0F;
      default: sum = '0;
    endcase
    unique case (io.op)
      ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_INC, ALU_DEC: begin
        io.y    = sum[NIB_W-1:0];
        io.cout = sum[NIB_W];
      end
      ALU_AND: io.y = io.a & io.b;
      ALU_EOR: io.y = io.a ^ io.b;
      ALU_OR:  io.y = io.a | io.b;
      ALU_SR0: io.y = {1'b0, io.a[3:1]};
      ALU_SR1: io.y = {1'b1, io.a[3:1]};
      ALU_SL0: io.y = {io.a[2:0], 1'b0};
      ALU_SL1: io.y = {io.a[2:0], 1'b1};
      ALU_DAA: begin
        if (!io.cin && io.a > NIB_NINE) begin
          io.y    = io.a + NIB_SIX;
          io.cout = 1'b1;
        end else if (io.cin && io.a <= NIB_THREE) begin
          io.y = io.a + NIB_SIX;
        end
      end
      ALU_DAS: begin
        if (!io.cin && io.a >= NIB_SIX)
          io.y = io.a + NIB_TEN;
      end
      ALU_PASS: io.y = io.b;
    endcase
    io.zero = (io.y == 4'h0);
  end

endmodule

//--- dv/core_datapath_bench.sv
// Self-checking bench for the core datapath.
// Assumes the decoder model drives every operation input.
`timescale 1ns/1ns
module core_datapath_bench
  import dp_pkg::*;
();
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  dp_op_t            op;
  alu_op_t           alu_op;
  logic              use_index, imm_operand, alu_to_ram;
  logic              ret_valid, skip_next, carry_flag, zero_flag;
  logic [DIR_AW-1:0] dir_addr;
  logic [3:0]        wr_sel;
  logic [7:0]        imm;
  logic [NIB_W-1:0]  store_data, accumulator, wr_data;
  logic [STK_W-1:0]  pc_in, ret_pc;
  logic [PTR_W-1:0]  table_addr;
  int                num_errors = 0;
  int                total_checks = 0;

  always #5 clk = ~clk;

  core_datapath core_datapath_inst (.clk, .rst, .op, .alu_op, .use_index,
    .dir_addr, .wr_sel, .imm, .imm_operand, .alu_to_ram, .store_data,
    .pc_in, .ret_pc, .ret_valid, .skip_next, .accumulator, .carry_flag,
    .zero_flag, .wr_data, .table_addr);
  decoder_model decoder_model_inst (.clk, .op, .alu_op, .use_index,
    .dir_addr, .wr_sel, .imm, .imm_operand, .alu_to_ram, .store_data,
    .pc_in);

  // X packs {alu_to_ram, imm_operand, wr_sel}
  task automatic gx(input dp_op_t o, input alu_op_t a, input logic ix,
                    input logic [11:0] v, input logic [5:0] x);
    decoder_model_inst.go(o, a, ix, v, x);
  endtask

  task automatic g(input dp_op_t o, input alu_op_t a, input logic ix,
                   input logic [11:0] v);
    gx(o, a, ix, v, 6'h00);
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #20000;
    num_errors++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    g(OP_NONE, ALU_ADD, 1'b0, 12'h000);
    chk({ret_valid, 11'h000}, 12'h000);
    g(OP_STORE, ALU_ADD, 1'b0, 12'h310);
    g(OP_STORE, ALU_ADD, 1'b0, 12'hA11);
    g(OP_STORE, ALU_ADD, 1'b0, 12'h112);
    g(OP_LOAD_LOW, ALU_ADD, 1'b0, 12'h010);
    g(OP_LOAD_HIGH, ALU_ADD, 1'b0, 12'h011);
    g(OP_LOAD_UPPER, ALU_ADD, 1'b0, 12'h012);
    g(OP_CMP_SKIP, ALU_ADD, 1'b0, 12'h0A3);
    chk(table_addr, 12'h1A3);
    g(OP_CMP_SKIP, ALU_ADD, 1'b0, 12'h0A2);
    chk({11'h000, skip_next}, 12'h001);
    g(OP_STORE, ALU_ADD, 1'b1, 12'h700);
    chk({11'h000, skip_next}, 12'h000);
    // Direct 23h shares low bits with pointer 1A3h
    g(OP_STORE, ALU_ADD, 1'b0, 12'h223);
    g(OP_ALU, ALU_ADD, 1'b1, 12'h000);
    g(OP_ALU, ALU_ADD, 1'b0, 12'h010);
    chk({8'h00, accumulator}, 12'h007);
    g(OP_ALU, ALU_DAA, 1'b0, 12'h010);
    chk({7'h00, carry_flag, accumulator}, 12'h00A);
    g(OP_ALU, ALU_DAS, 1'b0, 12'h010);
    chk({7'h00, carry_flag, accumulator}, 12'h010);
    g(OP_ALU, ALU_SUB, 1'b0, 12'h012);
    chk({7'h00, carry_flag, accumulator}, 12'h010);
    g(OP_ALU, ALU_DAS, 1'b0, 12'h010);
    chk({7'h00, carry_flag, accumulator}, 12'h00F);
    g(OP_NONE, ALU_ADD, 1'b0, 12'h000);
    chk({7'h00, carry_flag, accumulator}, 12'h009);
    for (int i = 1; i <= 9; i++) begin
      g(OP_CALL, ALU_ADD, 1'b0, 12'(i));
    end
    g(OP_RET, ALU_ADD, 1'b0, 12'h000);
    g(OP_RET, ALU_ADD, 1'b0, 12'h000);
    chk({ret_valid, ret_pc}, 12'h809);
    g(OP_RET, ALU_ADD, 1'b0, 12'h000);
    chk({ret_valid, ret_pc}, 12'h808);
    g(OP_NONE, ALU_ADD, 1'b0, 12'h000);
    chk({ret_valid, ret_pc}, 12'h807);
    // Working register 2 round trip, then immediate op into it
    gx(OP_MOVE_TO_WR, ALU_ADD, 1'b0, 12'h011, 6'h02);
    gx(OP_MOVE_FROM_WR, ALU_ADD, 1'b0, 12'h030, 6'h02);
    chk({8'h00, wr_data}, 12'h00A);
    g(OP_ALU, ALU_PASS, 1'b0, 12'h030);
    gx(OP_ALU, ALU_AND, 1'b0, 12'h005, 6'h32);
    chk({7'h00, carry_flag, accumulator}, 12'h00A);
    gx(OP_NONE, ALU_ADD, 1'b0, 12'h000, 6'h02);
    chk({3'h0, zero_flag, accumulator, wr_data}, 12'h100);
    // Logic, shift and arithmetic chain on the accumulator
    g(OP_ALU, ALU_OR, 1'b0, 12'h011);
    g(OP_ALU, ALU_EOR, 1'b0, 12'h010);
    chk({8'h00, accumulator}, 12'h00A);
    g(OP_ALU, ALU_SL1, 1'b0, 12'h000);
    chk({8'h00, accumulator}, 12'h009);
    g(OP_ALU, ALU_SL0, 1'b0, 12'h000);
    chk({8'h00, accumulator}, 12'h003);
    g(OP_ALU, ALU_SR0, 1'b0, 12'h000);
    chk({8'h00, accumulator}, 12'h006);
    g(OP_ALU, ALU_SR1, 1'b0, 12'h000);
    chk({8'h00, accumulator}, 12'h003);
    g(OP_ALU, ALU_INC, 1'b0, 12'h000);
    chk({8'h00, accumulator}, 12'h009);
    g(OP_ALU, ALU_DEC, 1'b0, 12'h000);
    chk({7'h00, carry_flag, accumulator}, 12'h00A);
    g(OP_ALU, ALU_SBC, 1'b0, 12'h011);
    chk({7'h00, carry_flag, accumulator}, 12'h019);
    g(OP_ALU, ALU_ADC, 1'b0, 12'h012);
    chk({7'h00, carry_flag, accumulator}, 12'h00F);
    g(OP_ALU, ALU_DAA, 1'b0, 12'h000);
    chk({6'h00, zero_flag, carry_flag, accumulator}, 12'h030);
    g(OP_NONE, ALU_ADD, 1'b0, 12'h000);
    chk({6'h00, zero_flag, carry_flag, accumulator}, 12'h016);
    g(OP_NONE, ALU_ADD, 1'b0, 12'h000);
    wrap_up();
  end
endmodule

//--- dv/core_datapath_monitor.sv
// Port-level assertions for the core datapath.
// Assumes one clock domain, synchronous active-high reset.
`timescale 1ns/1ns
module core_datapath_monitor
  import dp_pkg::*;
#(
  parameter int unsigned STACK_LEVELS = STK_DEPTH
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire dp_op_t            op,
  input wire alu_op_t           alu_op,
  input wire logic [7:0]        imm,
  input wire logic              ret_valid,
  input wire logic              skip_next,
  input wire logic [NIB_W-1:0]  accumulator,
  input wire logic              carry_flag,
  input wire logic [PTR_W-1:0]  table_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ret_pulse:
    assert property (op == OP_RET |=> ret_valid) else $error("no pop");
  a_ret_cause:
    assert property (ret_valid |-> $past(op) == OP_RET)
    else $error("stray pop");
  a_skip_equal:
    assert property (op == OP_CMP_SKIP && imm == table_addr[7:0]
      |=> skip_next) else $error("skip missing");
  a_skip_miss:
    assert property (op == OP_CMP_SKIP && imm != table_addr[7:0]
      |=> !skip_next) else $error("false skip");
  a_low_load:
    assert property (op == OP_LOAD_LOW |=> $stable(table_addr[11:4]))
    else $error("low load hit upper bits");
  a_ptr_steady:
    assert property (op inside {OP_NONE, OP_CMP_SKIP, OP_CALL, OP_RET}
      |=> $stable(table_addr)) else $error("pointer moved");
  a_acc_untouched:
    assert property (op inside {OP_LOAD_LOW, OP_LOAD_HIGH, OP_CMP_SKIP}
      |=> $stable(accumulator)) else $error("pointer leaked");
  a_daa_high:
    assert property (op == OP_ALU && alu_op == ALU_DAA && !carry_flag
      && accumulator > 4'h9 |=> carry_flag
      && accumulator == $past(accumulator) + 4'h6) else $error("daa");
  a_reset_clear:
    assert property ($fell(rst) |-> table_addr == 12'h000 && !ret_valid)
    else $error("reset state");
endmodule

bind core_datapath core_datapath_monitor #(.STACK_LEVELS(STACK_LEVELS))
  core_datapath_monitor_inst (.clk, .rst, .op, .alu_op, .imm, .ret_valid,
  .skip_next, .accumulator, .carry_flag, .table_addr);

//--- dv/decoder_model.sv
// Decoder and program counter stand-in issuing datapath ops.
// Assumes go() is called once per cycle; drives at falling edge.
`timescale 1ns/1ns
module decoder_model
  import dp_pkg::*;
(
  input  wire logic         clk,
  output dp_op_t            op,
  output alu_op_t           alu_op,
  output logic              use_index,
  output logic [DIR_AW-1:0] dir_addr,
  output logic [3:0]        wr_sel,
  output logic [7:0]        imm,
  output logic              imm_operand,
  output logic              alu_to_ram,
  output logic [NIB_W-1:0]  store_data,
  output logic [STK_W-1:0]  pc_in
);
  // X packs {alu_to_ram, imm_operand, wr_sel}
  task automatic put(input dp_op_t o, input alu_op_t a, input logic ix,
                     input logic [11:0] v, input logic [5:0] x);
    op = o;
    alu_op = a;
    use_index = ix;
    dir_addr = v[6:0];
    imm = v[7:0];
    store_data = v[11:8];
    pc_in = v[10:0];
    {alu_to_ram, imm_operand, wr_sel} = x;
  endtask

  task automatic go(input dp_op_t o, input alu_op_t a, input logic ix,
                    input logic [11:0] v, input logic [5:0] x);
    @(negedge clk);
    put(o, a, ix, v, x);
  endtask

  initial put(OP_NONE, ALU_ADD, 1'b0, 12'h000, 6'h00);
endmodule
